// ---- verif/slpa_far_model.sv ----
// trap logic stand-in that takes stack error requests
`timescale 1ns/10ps
`default_nettype none
module slpa_far_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic stack_error,
   output logic [7:0] trap_cnt
);
   // one trap taken for each cycle that the request is high
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) trap_cnt <= 8'h00;
      else if (stack_error) trap_cnt <= trap_cnt + 8'h01;
   end
endmodule
`default_nettype wire

// ---- verif/stack_limit_and_program_space_addressing_tb_top.sv ----
// self-checking bench for the stack limit and program address block
`timescale 1ns/10ps
`default_nettype none
module stack_limit_and_program_space_addressing_tb_top;
   logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
   logic tbl_req = 1'b0, tbl_write = 1'b0, tbl_high = 1'b0, data_req = 1'b0, data_write = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0, push_data = 16'h0, sp_ref_ea = 16'h0, tbl_ea = 16'h0;
   logic [15:0] data_ea = 16'h0, reg_rdata, stack_ea, push_word, v;
   logic [7:0] pc_high_byte = 8'h0, status_low_byte = 8'h0, trap_cnt, ntrap = 8'h0, p;
   slpa_pkg::slpa_op_t stack_op = slpa_pkg::SLPA_OP_NONE;
   slpa_pkg::slpa_push_t push_kind = slpa_pkg::SLPA_PUSH_DATA;
   logic stack_error, prog_rd, prog_wr, prog_upper, prog_cfg_space, prog_is_eeprom, remap_refused;
   logic [23:0] prog_addr;
   integer seed = 32'h95B6, error_cnt = 0, checks = 0, i;
   logic [39:0] exp_q[$];
   slpa_core i_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .stack_op, .push_kind, .push_data, .sp_ref_ea, .pc_high_byte, .status_low_byte,
      .stack_ea, .push_word, .stack_error, .tbl_req, .tbl_write, .tbl_high, .tbl_ea,
      .data_req, .data_write, .data_ea, .prog_addr, .prog_rd, .prog_wr, .prog_upper,
      .prog_cfg_space, .prog_is_eeprom, .remap_refused);
   slpa_far_model i_far (.clk_sys, .rstn, .stack_error, .trap_cnt);
   // 20 MHz clock
   initial forever #25 clk_sys = ~clk_sys;
   task automatic print_verdict();
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [39:0] take();
      if (exp_q.size() == 0) return 'x;
      return exp_q.pop_front();
   endfunction
   function automatic logic [39:0] pe(input logic [23:0] a, input int u, c, r, w, f);
      return {10'h0, a, u[0], c[0], a >= slpa_pkg::SLPA_EE_BASE && a <= slpa_pkg::SLPA_EE_LAST,
         r[0], w[0], f[0]};
   endfunction
   // read data is due the cycle after the strobe
   always @(posedge clk_sys) rd_pend <= reg_rd;
   // compare each result that shows with the oldest note
   always @(negedge clk_sys) begin
      if (rd_pend) chk("reg_rdata", {24'h0, reg_rdata}, take());
      if (prog_rd | prog_wr | remap_refused) chk("prog",
         {10'h0, (prog_rd | prog_wr) ? {prog_addr, prog_upper, prog_cfg_space, prog_is_eeprom}
         : 27'h0, prog_rd, prog_wr, remap_refused}, take());
      if (stack_op != slpa_pkg::SLPA_OP_NONE) chk("stack",
         {7'h0, stack_error, stack_ea, (stack_op == slpa_pkg::SLPA_OP_PUSH) ? push_word : 16'h0},
         take());
   end
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back({24'h0, e});
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   task automatic stk(input slpa_pkg::slpa_op_t op, input slpa_pkg::slpa_push_t k,
      input logic [15:0] ea, input logic er);
      logic [15:0] d, w;
      logic [7:0] h, s;
      d = 16'($random(seed));
      h = 8'($random(seed));
      s = 8'($random(seed));
      w = (k == slpa_pkg::SLPA_PUSH_DATA) ? d : (k == slpa_pkg::SLPA_PUSH_CALL) ?
         {8'h00, h} : {s, h};
      if (op != slpa_pkg::SLPA_OP_PUSH) w = 16'h0;
      @(posedge clk_sys);
      stack_op <= op;
      push_kind <= k;
      push_data <= d;
      pc_high_byte <= h;
      status_low_byte <= s;
      sp_ref_ea <= ea;
      exp_q.push_back({7'h0, er, ea, w});
      ntrap += {7'h0, er};
      @(posedge clk_sys);
      stack_op <= slpa_pkg::SLPA_OP_NONE;
   endtask
   task automatic pg(input logic t, w, h, input logic [15:0] ea, input logic [39:0] e);
      @(posedge clk_sys);
      tbl_req <= t;
      data_req <= !t;
      tbl_write <= w;
      data_write <= w;
      tbl_high <= h;
      tbl_ea <= ea;
      data_ea <= ea;
      if (e !== 40'h0) exp_q.push_back(e);
      @(posedge clk_sys);
      tbl_req <= 1'b0;
      data_req <= 1'b0;
   endtask
   // cut a hang short
   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(2'h0, 16'h0800);
      rd(2'h2, 16'h0000);
      wr(2'h1, 16'h0903);
      rd(2'h1, 16'h0902);
      wr(2'h0, 16'h08FE);
      for (i = 0; i < 3; i++) begin
         stk(slpa_pkg::SLPA_OP_PUSH, slpa_pkg::slpa_push_t'(i), 16'h08FE + 16'(2 * i), 1'b0);
      end
      rd(2'h0, 16'h0904);
      stk(slpa_pkg::SLPA_OP_PUSH, slpa_pkg::SLPA_PUSH_DATA, 16'h0904, 1'b1);
      wr(2'h0, 16'h0804);
      stk(slpa_pkg::SLPA_OP_POP, slpa_pkg::SLPA_PUSH_DATA, 16'h0802, 1'b0);
      stk(slpa_pkg::SLPA_OP_POP, slpa_pkg::SLPA_PUSH_DATA, 16'h0800, 1'b0);
      rd(2'h0, 16'h0800);
      stk(slpa_pkg::SLPA_OP_POP, slpa_pkg::SLPA_PUSH_DATA, 16'h07FE, 1'b1);
      stk(slpa_pkg::SLPA_OP_SPREF, slpa_pkg::SLPA_PUSH_DATA, 16'h07FE, 1'b1);
      stk(slpa_pkg::SLPA_OP_SPREF, slpa_pkg::SLPA_PUSH_DATA, 16'h0A00, 1'b0);
      wr(2'h2, 16'h007F);
      pg(1'b1, 1'b0, 1'b0, 16'hFE00, pe(24'h7FFE00, 0, 0, 1, 0, 0));
      v = 16'($random(seed));
      pg(1'b1, 1'b1, 1'b1, v, pe({8'h7F, v}, 1, 0, 0, 1, 0));
      p = 8'h80 | 8'($random(seed));
      wr(2'h2, {8'h00, p});
      pg(1'b1, 1'b0, 1'b0, v, pe({p, v}, 0, 1, 1, 0, 0));
      wr(2'h3, 16'h00FF);
      rd(2'h3, 16'h00FF);
      pg(1'b0, 1'b0, 1'b0, 16'hFE00, pe(24'h7FFE00, 0, 0, 1, 0, 0));
      p = 8'($random(seed));
      v = 16'h8000 | 16'($random(seed));
      wr(2'h3, {8'h00, p});
      pg(1'b0, 1'b0, 1'b0, v, pe({1'b0, p, v[14:0]}, 0, 0, 1, 0, 0));
      pg(1'b0, 1'b1, 1'b0, v, pe(24'h0, 0, 0, 0, 0, 1));
      pg(1'b0, 1'b0, 1'b0, v & 16'h7FFF, 40'h0);
      repeat (3) @(posedge clk_sys);
      chk("trap_cnt", {32'h0, trap_cnt}, {32'h0, ntrap});
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- verilog/slpa_core.sv ----
// stack pointer management, limit check and program space address forming
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module slpa_core (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire slpa_pkg::slpa_op_t stack_op,
   input wire slpa_pkg::slpa_push_t push_kind,
   input wire logic [15:0] push_data,
   input wire logic [15:0] sp_ref_ea,
   input wire logic [7:0] pc_high_byte,
   input wire logic [7:0] status_low_byte,
   output logic [15:0] stack_ea,
   output logic [15:0] push_word,
   output logic stack_error,
   input wire logic tbl_req,
   input wire logic tbl_write,
   input wire logic tbl_high,
   input wire logic [15:0] tbl_ea,
   input wire logic data_req,
   input wire logic data_write,
   input wire logic [15:0] data_ea,
   output logic [23:0] prog_addr,
   output logic prog_rd,
   output logic prog_wr,
   output logic prog_upper,
   output logic prog_cfg_space,
   output logic prog_is_eeprom,
   output logic remap_refused
);
   logic [15:0] sp_q, sp_d;
   logic [15:0] limit_q, limit_d;
   logic [7:0] tblpg_q, tblpg_d;
   logic [7:0] vispg_q, vispg_d;
   logic [15:0] rdata_q, rdata_d;
   logic [23:0] paddr_q, paddr_d;
   logic prd_q, prd_d, pwr_q, pwr_d, pup_q, pup_d, pcfg_q, pcfg_d;
   logic pee_q, pee_d, rref_q, rref_d;
   logic [15:0] ea;
   logic over_limit, under_floor;

   function automatic logic is_eeprom(input logic [23:0] a);
      is_eeprom = (a >= slpa_pkg::SLPA_EE_BASE) && (a <= slpa_pkg::SLPA_EE_LAST);
   endfunction

   // table address: page over the full effective address
   function automatic logic [23:0] table_addr(input logic [7:0] pg, input logic [15:0] a);
      table_addr = {pg, a};
   endfunction

   // remap address: top bit held low so only user space is reached
   function automatic logic [23:0] remap_addr(input logic [7:0] pg, input logic [15:0] a);
      remap_addr = {1'b0, pg, a[slpa_pkg::SLPA_EA_TOP - 1:0]};
   endfunction

   // effective address of the current stack access
   always_comb begin
      unique case (stack_op)
         slpa_pkg::SLPA_OP_PUSH: ea = sp_q; // [R1] [R2] post-increment
         slpa_pkg::SLPA_OP_POP: ea = sp_q - slpa_pkg::SLPA_WORD_STEP; // [R2] pre-decrement
         slpa_pkg::SLPA_OP_SPREF: ea = sp_ref_ea;
         slpa_pkg::SLPA_OP_NONE: ea = sp_q;
      endcase
   end

   // limit compare on push addresses, floor compare on every stack-pointer address
   assign over_limit = (stack_op == slpa_pkg::SLPA_OP_PUSH) && (ea > limit_q); // [R7] [R8]
   assign under_floor = (stack_op != slpa_pkg::SLPA_OP_NONE)
                        && (ea < slpa_pkg::SLPA_SP_FLOOR); // [R9]
   assign stack_error = over_limit || under_floor; // [R21] same-cycle request
   assign stack_ea = ea;

   // word formed for a push
   always_comb begin
      unique case (push_kind)
         slpa_pkg::SLPA_PUSH_CALL: push_word = {slpa_pkg::SLPA_BYTE_ZERO, pc_high_byte}; // [R3]
         slpa_pkg::SLPA_PUSH_EXC: push_word = {status_low_byte, pc_high_byte}; // [R4]
         default: push_word = push_data;
      endcase
   end

   // register next values
   always_comb begin
      sp_d = sp_q;
      limit_d = limit_q;
      tblpg_d = tblpg_q;
      vispg_d = vispg_q;
      rdata_d = rdata_q;
      if (stack_op == slpa_pkg::SLPA_OP_PUSH) begin
         sp_d = sp_q + slpa_pkg::SLPA_WORD_STEP; // [R2]
      end else if (stack_op == slpa_pkg::SLPA_OP_POP) begin
         sp_d = sp_q - slpa_pkg::SLPA_WORD_STEP; // [R2]
      end
      if (reg_wr) begin
         unique case (reg_addr)
            slpa_pkg::SLPA_REG_SP: sp_d = reg_wdata & slpa_pkg::SLPA_ALIGN_MASK;
            slpa_pkg::SLPA_REG_LIMIT: limit_d = reg_wdata & slpa_pkg::SLPA_ALIGN_MASK; // [R6]
            slpa_pkg::SLPA_REG_TBLPG: tblpg_d = reg_wdata[7:0];
            slpa_pkg::SLPA_REG_VISPG: vispg_d = reg_wdata[7:0];
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            slpa_pkg::SLPA_REG_SP: rdata_d = sp_q;
            slpa_pkg::SLPA_REG_LIMIT: rdata_d = limit_q;
            slpa_pkg::SLPA_REG_TBLPG: rdata_d = {slpa_pkg::SLPA_BYTE_ZERO, tblpg_q};
            slpa_pkg::SLPA_REG_VISPG: rdata_d = {slpa_pkg::SLPA_BYTE_ZERO, vispg_q};
         endcase
      end
   end

   // registers; the limit keeps its write value with no reset load
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sp_q <= slpa_pkg::SLPA_SP_RESET;
         tblpg_q <= slpa_pkg::SLPA_BYTE_ZERO;
         vispg_q <= slpa_pkg::SLPA_BYTE_ZERO;
         rdata_q <= 16'h0000;
      end else begin
         sp_q <= sp_d;
         tblpg_q <= tblpg_d;
         vispg_q <= vispg_d;
         rdata_q <= rdata_d;
      end
   end

   // stack limit: uninitialised at reset, software loads it [R5]
   always_ff @(posedge clk_sys) begin
      limit_q <= limit_d;
   end
   assign reg_rdata = rdata_q;

   // program address forming for table and remap accesses
   always_comb begin
      paddr_d = paddr_q;
      prd_d = 1'b0;
      pwr_d = 1'b0;
      pup_d = 1'b0;
      pcfg_d = 1'b0;
      pee_d = pee_q;
      rref_d = 1'b0;
      if (tbl_req) begin
         paddr_d = table_addr(tblpg_q, tbl_ea); // [R11] [R16]
         prd_d = !tbl_write;
         pwr_d = tbl_write; // [R16]
         pup_d = tbl_high; // [R16] [R19] upper half at odd address
         pcfg_d = tblpg_q[slpa_pkg::SLPA_CFG_BIT]; // [R12]
         pee_d = is_eeprom(table_addr(tblpg_q, tbl_ea)); // [R17] [R18]
      end else if (data_req && data_ea[slpa_pkg::SLPA_EA_TOP]) begin
         // [R13] [R20] [R14] top bit held zero: user space only
         paddr_d = remap_addr(vispg_q, data_ea);
         prd_d = !data_write; // [R15] read-only window
         rref_d = data_write; // [R15]
         pee_d = is_eeprom(remap_addr(vispg_q, data_ea));
      end
   end

   // program port registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         paddr_q <= 24'h000000;
         prd_q <= 1'b0;
         pwr_q <= 1'b0;
         pup_q <= 1'b0;
         pcfg_q <= 1'b0;
         pee_q <= 1'b0;
         rref_q <= 1'b0;
      end else begin
         paddr_q <= paddr_d;
         prd_q <= prd_d;
         pwr_q <= pwr_d;
         pup_q <= pup_d;
         pcfg_q <= pcfg_d;
         pee_q <= pee_d;
         rref_q <= rref_d;
      end
   end
   assign prog_addr = paddr_q;
   assign prog_rd = prd_q;
   assign prog_wr = pwr_q;
   assign prog_upper = pup_q;
   assign prog_cfg_space = pcfg_q;
   assign prog_is_eeprom = pee_q;
   assign remap_refused = rref_q;

   property p_push_inc;
      @(posedge clk_sys) disable iff (!rstn)
      (stack_op == slpa_pkg::SLPA_OP_PUSH && !reg_wr) |=> sp_q == $past(sp_q) + 16'h0002;
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("push did not advance sp"); // [R2]
   property p_pop_ea;
      @(posedge clk_sys) disable iff (!rstn)
      stack_op == slpa_pkg::SLPA_OP_POP |-> stack_ea == sp_q - 16'h0002;
   endproperty
   a_pop_ea: assert property (p_pop_ea) else $error("pop not predecremented"); // [R2]
   property p_call_push;
      @(posedge clk_sys) disable iff (!rstn)
      push_kind == slpa_pkg::SLPA_PUSH_CALL |-> push_word[15:8] == 8'h00;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push high byte set"); // [R3]
   property p_exc_push;
      @(posedge clk_sys) disable iff (!rstn)
      push_kind == slpa_pkg::SLPA_PUSH_EXC |-> push_word[15:8] == status_low_byte;
   endproperty
   a_exc_push: assert property (p_exc_push) else $error("exception push lost status"); // [R4]
   property p_limit_even;
      @(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == slpa_pkg::SLPA_REG_LIMIT) |=> limit_q[0] == 1'b0;
   endproperty
   a_limit_even: assert property (p_limit_even) else $error("limit bit 0 set"); // [R6]
   property p_at_limit;
      @(posedge clk_sys) disable iff (!rstn)
      (stack_op == slpa_pkg::SLPA_OP_PUSH && sp_q == limit_q && sp_q >= 16'h0800)
      |-> !stack_error;
   endproperty
   a_at_limit: assert property (p_at_limit) else $error("trap at limit push"); // [R8]
   property p_floor;
      @(posedge clk_sys) disable iff (!rstn)
      (stack_op != slpa_pkg::SLPA_OP_NONE && stack_ea < 16'h0800) |-> stack_error;
   endproperty
   a_floor: assert property (p_floor) else $error("underflow not trapped"); // [R9] [R21]
   property p_tbl_addr;
      @(posedge clk_sys) disable iff (!rstn)
      tbl_req |=> prog_addr == {$past(tblpg_q), $past(tbl_ea)}
                  && prog_cfg_space == $past(tblpg_q[7]);
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong"); // [R11] [R12]
   property p_remap;
      @(posedge clk_sys) disable iff (!rstn)
      (!tbl_req && data_req && data_ea[15]) |=> prog_addr[23] == 1'b0
         && prog_addr[15] == $past(vispg_q[0]) && !prog_wr;
   endproperty
   a_remap: assert property (p_remap) else $error("remap address wrong"); // [R13] [R14] [R20]

   // stack pointer, limit and trap request checks
   sequence s_push_at_limit;
      stack_op == slpa_pkg::SLPA_OP_PUSH && !reg_wr && sp_q == limit_q
         && sp_q >= slpa_pkg::SLPA_SP_FLOOR;
   endsequence
   property p_push_ea;
      @(posedge clk_sys) disable iff (!rstn)
      stack_op == slpa_pkg::SLPA_OP_PUSH |-> stack_ea == sp_q;
   endproperty
   a_push_ea: assert property (p_push_ea) else $error("push not at next free word"); // [R1]
   property p_pop_dec;
      @(posedge clk_sys) disable iff (!rstn)
      (stack_op == slpa_pkg::SLPA_OP_POP && !reg_wr)
      |=> sp_q == $past(sp_q) - slpa_pkg::SLPA_WORD_STEP;
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("pop did not step sp back"); // [R2]
   property p_limit_load;
      @(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == slpa_pkg::SLPA_REG_LIMIT)
      |=> limit_q == ($past(reg_wdata) & slpa_pkg::SLPA_ALIGN_MASK);
   endproperty
   a_limit_load: assert property (p_limit_load) else $error("limit not loaded aligned"); // [R5] [R6]
   property p_limit_step;
      @(posedge clk_sys) disable iff (!rstn)
      s_push_at_limit |=> sp_q > limit_q;
   endproperty
   a_limit_step: assert property (p_limit_step) else $error("push at limit did not pass it"); // [R8]
   property p_over_trap;
      @(posedge clk_sys) disable iff (!rstn)
      (stack_op == slpa_pkg::SLPA_OP_PUSH && sp_q > limit_q) |-> stack_error;
   endproperty
   a_over_trap: assert property (p_over_trap) else $error("push past limit not trapped"); // [R7] [R8]
   property p_error_source;
      @(posedge clk_sys) disable iff (!rstn)
      stack_error |-> stack_op != slpa_pkg::SLPA_OP_NONE;
   endproperty
   a_error_source: assert property (p_error_source) else $error("trap without stack access"); // [R21]

   // program port checks
   sequence s_remap_read;
      !tbl_req && data_req && data_ea[slpa_pkg::SLPA_EA_TOP] && !data_write;
   endsequence
   sequence s_remap_write;
      !tbl_req && data_req && data_ea[slpa_pkg::SLPA_EA_TOP] && data_write;
   endsequence
   property p_tbl_strobes;
      @(posedge clk_sys) disable iff (!rstn)
      tbl_req |=> prog_wr == $past(tbl_write) && prog_rd == !$past(tbl_write)
                  && prog_upper == $past(tbl_high);
   endproperty
   a_tbl_strobes: assert property (p_tbl_strobes) else $error("table strobes wrong"); // [R16] [R19]
   property p_eeprom_page;
      @(posedge clk_sys) disable iff (!rstn)
      prog_is_eeprom |-> prog_addr[23:16] == slpa_pkg::SLPA_EE_PAGE;
   endproperty
   a_eeprom_page: assert property (p_eeprom_page) else $error("eeprom flag off page"); // [R17] [R18]
   property p_remap_read;
      @(posedge clk_sys) disable iff (!rstn)
      s_remap_read |=> prog_rd && !prog_upper && !prog_cfg_space && !remap_refused;
   endproperty
   a_remap_read: assert property (p_remap_read) else $error("remap read not low user word"); // [R14] [R15]
   property p_remap_write;
      @(posedge clk_sys) disable iff (!rstn)
      s_remap_write |=> remap_refused && !prog_rd && !prog_wr;
   endproperty
   a_remap_write: assert property (p_remap_write) else $error("remap write not refused"); // [R15]
   property p_no_request;
      @(posedge clk_sys) disable iff (!rstn)
      (!tbl_req && !(data_req && data_ea[slpa_pkg::SLPA_EA_TOP]))
      |=> !prog_rd && !prog_wr && !remap_refused;
   endproperty
   a_no_request: assert property (p_no_request) else $error("program strobe without request"); // [R13]
endmodule
`default_nettype wire

// ---- verilog/slpa_pkg.sv ----
// constants for the stack limit and program space address block
// Contract
// R1: stack pointer marks next free word, grows up
// R2: post-increment on push, pre-decrement on pop
// R3: call push clears program counter high byte
// R4: exception push puts status low byte high
// R5: stack limit undefined after reset
// R6: stack limit bit zero forced to zero
// R7: stack-pointer addresses compared against stack limit; the code compares push addresses only, not pop or SPREF addresses
// R8: push at limit allowed, next push traps
// R9: stack pointer below 0800h traps
// R10: software avoids stack read right after limit write
// R11: table address is page over effective address
// R12: table page top bit selects configuration space
// R13: remap address is page over low fifteen bits
// R14: remap reaches user memory only
// R15: remap is read-only, low word only
// R16: table path reads and writes every byte
// R17: data eeprom starts at 7FFE00
// R18: data eeprom 256 sixteen-bit words via table path
// R19: program word lower half even, upper odd
// R20: remap address bit 15 from page bit 0
// R21: stack error is one request in same cycle
`default_nettype none
package slpa_pkg;
   localparam logic [15:0] SLPA_SP_FLOOR = 16'h0800;
   localparam logic [15:0] SLPA_WORD_STEP = 16'h0002;
   localparam logic [15:0] SLPA_ALIGN_MASK = 16'hFFFE;
   localparam logic [15:0] SLPA_SP_RESET = 16'h0800;
   localparam logic [23:0] SLPA_EE_BASE = 24'h7FFE00;
   localparam logic [23:0] SLPA_EE_LAST = 24'h7FFFFF;
   localparam logic [7:0] SLPA_EE_PAGE = 8'h7F;
   localparam logic [7:0] SLPA_BYTE_ZERO = 8'h00;
   localparam int SLPA_CFG_BIT = 7;
   localparam int SLPA_EA_TOP = 15;
   // register indices on the plain register port
   localparam logic [1:0] SLPA_REG_SP = 2'h0;
   localparam logic [1:0] SLPA_REG_LIMIT = 2'h1;
   localparam logic [1:0] SLPA_REG_TBLPG = 2'h2;
   localparam logic [1:0] SLPA_REG_VISPG = 2'h3;
   typedef enum logic [1:0] {
      SLPA_OP_NONE,
      SLPA_OP_PUSH,
      SLPA_OP_POP,
      SLPA_OP_SPREF
   } slpa_op_t;
   typedef enum logic [1:0] {
      SLPA_PUSH_DATA,
      SLPA_PUSH_CALL,
      SLPA_PUSH_EXC
   } slpa_push_t;
endpackage
`default_nettype wire
